// file: design/aux_cmd_regs.svh
// register offsets, command codes and reset values for the command decoder
`ifndef AUX_CMD_REGS_SVH
`define AUX_CMD_REGS_SVH

// register offsets on the plain port
`define ADDR_AUX_COMMAND 3'h5
`define ADDR_ADDRESS_STATUS 3'h4
// command byte fields
`define CMD_SET_BIT 7
`define CMD_CODE_HI 4
// five-bit function codes
`define FC_SWRST 5'h00
`define FC_DAC_REL 5'h01
`define FC_RHDF 5'h02
`define FC_HDFA 5'h03
`define FC_HDFE 5'h04
`define FC_NBAF 5'h05
`define FC_FGET 5'h06
`define FC_RTL 5'h07
`define FC_FEOI 5'h08
`define FC_LON 5'h09
`define FC_TON 5'h0A
`define FC_GTS 5'h0B
`define FC_TCA 5'h0C
`define FC_TCS 5'h0D
`define FC_RPP 5'h0E
`define FC_SIC 5'h0F
`define FC_SRE 5'h10
`define FC_RQC 5'h11
`define FC_RLC 5'h12
`define FC_DAI 5'h13
`define FC_PTS 5'h14
`define FC_STDL 5'h15
`define FC_SHDW 5'h16
`define FC_VSTDL 5'h17
`define FC_SRQ_B 5'h18
`define FC_MODE 5'h19
`define FC_REQ 5'h1A
`define FC_CHRST 5'h1C
`define FC_IST 5'h1D
`define FC_PAGE_A 5'h1E
`define FC_PAGE_B 5'h1F
// flag indices in the static flag vector
`define FL_SWRST 0
`define FL_HDFA 1
`define FL_HDFE 2
`define FL_FGET 3
`define FL_RTL 4
`define FL_LON 5
`define FL_TON 6
`define FL_RPP 7
`define FL_SIC 8
`define FL_SRE 9
`define FL_DAI 10
`define FL_STDL 11
`define FL_SHDW 12
`define FL_VSTDL 13
`define FL_SRQ_B 14
`define FL_IST 15
`define NUM_FLAGS 16
// flags after reset: software reset is set, all else clear
`define FLAGS_RESET 16'h0001
`define PAGE_RESET 3'h0
`endif

// file: design/aux_cmd_pkg.sv
// types shared by the command decoder
package aux_cmd_pkg;
  // pulsed command strobes, one bit each
  typedef struct packed {
    logic dacInvalid;
    logic dacValid;
    logic releaseRfd;
    logic nbaFalse;
    logic sendEoi;
    logic goStandby;
    logic takeAsync;
    logic takeSync;
    logic reqControl;
    logic relControl;
    logic passSecondary;
    logic modeSwitch;
    logic rsvFalse;
    logic rsvTrue;
    logic chipReset;
  } pulses_t;
  // which hidden register is paged in
  typedef enum logic [2:0] {
    PAGE_NONE,
    PAGE_IRQ_MASK_B,
    PAGE_BUS_CTRL,
    PAGE_EOS,
    PAGE_ACCESSORY
  } page_t;
endpackage

// file: design/aux_command_decoder.sv
// auxiliary command decoder with address status reporting
`timescale 1ns/1ps
`include "aux_cmd_regs.svh"

module aux_command_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // address status inputs from the interface functions
  input wire logic primaryValid,
  input wire logic primaryLsb,
  input wire logic [6:0] statusUpper,
  // static feature flags
  output logic [15:0] flags,
  // pulsed command strobes
  output aux_cmd_pkg::pulses_t pulses,
  // paged-in register selection
  output aux_cmd_pkg::page_t page,
  // interface functions held idle
  output logic functionsIdle
);
  import aux_cmd_pkg::*;

  logic ulpa;
  logic next_ulpa;
  logic [15:0] next_flags;
  pulses_t next_pulses;
  page_t next_page;
  logic [7:0] next_rdData;

  // command decode wires
  wire cmdWrite = regWrite && (regAddr == `ADDR_AUX_COMMAND);
  wire setBit = regWrData[`CMD_SET_BIT];
  wire [4:0] code = regWrData[`CMD_CODE_HI:0];
  // cmd byte format: bits 6 and 5 must be zero to decode
  wire wellFormed = (regWrData[6:5] == 2'b00);
  wire cmdValid = cmdWrite && wellFormed;

  function automatic logic hit(input logic [4:0] c, input logic [4:0] f);
    hit = (c == f);
  endfunction

  // static code to flag index; 5'h1F means not a static command
  function automatic logic [4:0] flagIndex(input logic [4:0] c);
    case (c)
      `FC_SWRST: flagIndex = 5'(`FL_SWRST);
      `FC_HDFA: flagIndex = 5'(`FL_HDFA);
      `FC_HDFE: flagIndex = 5'(`FL_HDFE);
      `FC_FGET: flagIndex = 5'(`FL_FGET);
      `FC_RTL: flagIndex = 5'(`FL_RTL);
      `FC_LON: flagIndex = 5'(`FL_LON);
      `FC_TON: flagIndex = 5'(`FL_TON);
      `FC_RPP: flagIndex = 5'(`FL_RPP);
      `FC_SIC: flagIndex = 5'(`FL_SIC);
      `FC_SRE: flagIndex = 5'(`FL_SRE);
      `FC_DAI: flagIndex = 5'(`FL_DAI);
      `FC_STDL: flagIndex = 5'(`FL_STDL);
      `FC_SHDW: flagIndex = 5'(`FL_SHDW);
      `FC_VSTDL: flagIndex = 5'(`FL_VSTDL);
      `FC_SRQ_B: flagIndex = 5'(`FL_SRQ_B);
      `FC_IST: flagIndex = 5'(`FL_IST);
      default: flagIndex = 5'h1F;
    endcase
  endfunction

  wire [4:0] fIdx = flagIndex(code);
  wire isStatic = (fIdx != 5'h1F);

  // pulsed decode; reserved codes fall through to nothing
  wire pChipRst = cmdValid && !setBit && hit(code, `FC_CHRST);
  always_comb begin
    next_pulses = '0;
    if (cmdValid) begin
      // DAC release, valid or not by the set bit
      next_pulses.dacInvalid = !setBit && hit(code, `FC_DAC_REL);
      next_pulses.dacValid = setBit && hit(code, `FC_DAC_REL);
      next_pulses.releaseRfd = !setBit && hit(code, `FC_RHDF);
      next_pulses.nbaFalse = !setBit && hit(code, `FC_NBAF);
      next_pulses.sendEoi = !setBit && hit(code, `FC_FEOI);
      next_pulses.goStandby = !setBit && hit(code, `FC_GTS);
      next_pulses.takeAsync = !setBit && hit(code, `FC_TCA);
      next_pulses.takeSync = !setBit && hit(code, `FC_TCS);
      next_pulses.reqControl = !setBit && hit(code, `FC_RQC);
      next_pulses.relControl = !setBit && hit(code, `FC_RLC);
      next_pulses.modeSwitch = setBit && hit(code, `FC_MODE);
      next_pulses.chipReset = pChipRst;
      next_pulses.passSecondary = !setBit && hit(code, `FC_PTS);
      next_pulses.rsvFalse = !setBit && hit(code, `FC_REQ);
      next_pulses.rsvTrue = setBit && hit(code, `FC_REQ);
    end
  end

  // static flags; set bit decides value
  always_comb begin
    next_flags = flags;
    // chip reset sets software reset, clears holdoffs
    if (pChipRst) begin
      next_flags = `FLAGS_RESET;
    end else if (cmdValid && isStatic) begin
      next_flags[fIdx[3:0]] = setBit;
    end
  end

  // page-in selection, held until cleared or replaced
  always_comb begin
    next_page = page;
    if (pChipRst) begin
      next_page = PAGE_NONE;
    end else if (cmdValid && !setBit && hit(code, `FC_PAGE_A)) begin
      next_page = PAGE_IRQ_MASK_B;
    end else if (cmdValid && !setBit && hit(code, `FC_PAGE_B)) begin
      next_page = PAGE_BUS_CTRL;
    end else if (cmdValid && setBit && hit(code, `FC_PAGE_A)) begin
      next_page = PAGE_EOS;
    end else if (cmdValid && setBit && hit(code, `FC_PAGE_B)) begin
      next_page = PAGE_ACCESSORY;
    end else if (cmdValid && setBit && hit(code, `FC_CHRST)) begin
      next_page = PAGE_NONE;
    end
  end

  // ulpa tracks last primary address; chip reset wins
  assign next_ulpa = pChipRst ? 1'b0 :
                     primaryValid ? primaryLsb : ulpa;

  // read data; command register reads as zero (write only)
  assign next_rdData = (regRead && regAddr == `ADDR_ADDRESS_STATUS) ?
                       {statusUpper, ulpa} : 8'h00;

  // strobes registered so each lasts one clock
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pulses <= '0;
      flags <= `FLAGS_RESET;
      page <= PAGE_NONE;
      ulpa <= 1'b0;
      regRdData <= 8'h00;
      functionsIdle <= 1'b1;
    end else begin
      pulses <= next_pulses;
      flags <= next_flags;
      page <= next_page;
      ulpa <= next_ulpa;
      regRdData <= next_rdData;
      functionsIdle <= next_flags[`FL_SWRST];
    end
  end

  pulse_single_a: assert property (@(posedge sys_clk) disable iff (reset)
    pulses.sendEoi |=> !pulses.sendEoi)
    else $error("send EOI strobe longer than one cycle");

  sequence eoiWrite_s;
    cmdWrite && regWrData == 8'h08;
  endsequence
  eoi_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    eoiWrite_s |=> pulses.sendEoi)
    else $error("EOI strobe missing after command");

  dac_valid_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h81 |=> pulses.dacValid && !pulses.dacInvalid)
    else $error("valid DAC release not strobed");

  hdfa_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h83 |=> flags[`FL_HDFA])
    else $error("holdoff all data not set");

  flag_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !cmdWrite |=> $stable(flags))
    else $error("flags changed without a command");

  ulpa_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h1C |=> !ulpa ##1 pulses.chipReset == 1'b0)
    else $error("chip reset did not clear ulpa");

  ulpa_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    regRead && regAddr == `ADDR_ADDRESS_STATUS |=> regRdData[0] == $past(ulpa))
    else $error("address status bit 0 wrong");

  swrst_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h80 |=> functionsIdle [*1] ##1 flags[`FL_SWRST])
    else $error("software reset not holding idle");

  sre_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h90 |=> flags[`FL_SRE])
    else $error("remote enable flag not set");

  page_irq_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h1E |=> page == PAGE_IRQ_MASK_B)
    else $error("page-in of mask b missing");

  dac_invalid_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h01 |=> pulses.dacInvalid)
    else $error("nonvalid DAC release not strobed");

  rfd_release_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h02 |=> pulses.releaseRfd)
    else $error("RFD release not strobed");

  hdfa_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h03 |=> !flags[`FL_HDFA])
    else $error("holdoff all data not cleared");

  hdfe_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h84 |=> flags[`FL_HDFE])
    else $error("holdoff on end not set");

  hdfe_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h04 |=> !flags[`FL_HDFE])
    else $error("holdoff on end not cleared");

  nbaf_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h05 |=> pulses.nbaFalse)
    else $error("nba false strobe missing");

  fget_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h86 |=> flags[`FL_FGET])
    else $error("trigger flag not set");

  fget_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h06 |=> !flags[`FL_FGET])
    else $error("trigger flag not cleared");

  rtl_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h87 |=> flags[`FL_RTL])
    else $error("return to local not set");

  rtl_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h07 |=> !flags[`FL_RTL])
    else $error("return to local not cleared");

  rpp_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h8E |=> flags[`FL_RPP])
    else $error("poll request not set");

  rpp_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h0E |=> !flags[`FL_RPP])
    else $error("poll request not cleared");

  sic_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h8F |=> flags[`FL_SIC])
    else $error("interface clear not set");

  sre_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h10 |=> !flags[`FL_SRE])
    else $error("remote enable not cleared");

  dai_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h93 |=> flags[`FL_DAI])
    else $error("interrupt disable not set");

  dai_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h13 |=> !flags[`FL_DAI])
    else $error("interrupt disable not cleared");

  pass_sec_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h14 |=> pulses.passSecondary)
    else $error("pass through strobe missing");

  stdl_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h95 |=> flags[`FL_STDL])
    else $error("short delay not set");

  vstdl_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h97 |=> flags[`FL_VSTDL])
    else $error("very short delay not set");

  srq_b_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h98 |=> flags[`FL_SRQ_B])
    else $error("service flag b not set");

  rsv_false_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h1A |=> pulses.rsvFalse)
    else $error("rsv false strobe missing");

  rsv_true_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h9A |=> pulses.rsvTrue)
    else $error("rsv true strobe missing");

  ist_set_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h9D |=> flags[`FL_IST])
    else $error("poll flag not set");

  ist_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h1D |=> !flags[`FL_IST])
    else $error("poll flag not cleared");

  page_eos_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h9E |=> page == PAGE_EOS)
    else $error("end of string page-in missing");

  page_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h9C |=> page == PAGE_NONE)
    else $error("page-ins not cleared");

  swrst_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h00 |=> !functionsIdle)
    else $error("functions still held idle");

  malformed_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData[6:5] != 2'b00 |=> pulses == '0)
    else $error("malformed byte produced a strobe");

  listen_only_a: assert property (@(posedge sys_clk) disable iff (reset)
    cmdWrite && regWrData == 8'h89 |=> flags[`FL_LON])
    else $error("listen only not set");
endmodule

// file: tb/aux_host_model.sv
// host model driving the command decoder's register port
`timescale 1ns/1ps

module aux_host_model (
  // clock
  input wire logic sys_clk,
  // register port toward the decoder
  output logic [2:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input wire logic [7:0] regRdData
);
  // idle bus at time zero
  initial begin
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // one write cycle; released lines show the inverse, never a stale copy
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    repeat (3) @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  // one read cycle; data is only good in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask
endmodule

// file: tb/gpib_aux_command_decoder_tb_top.sv
// self-checking testbench for the auxiliary command decoder
`timescale 1ns/1ps
`include "aux_cmd_regs.svh"

module gpib_aux_command_decoder_tb_top import aux_cmd_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, rd;
  logic regWrite, regRead, functionsIdle;
  logic primaryValid = 1'b0;
  logic primaryLsb = 1'b0;
  logic expUlpa = 1'b0;
  logic [6:0] statusUpper = 7'h00;
  logic [15:0] flags;
  logic [15:0] expFlags = 16'h0001;
  pulses_t pulses;
  page_t page;
  page_t expPage = PAGE_NONE;
  int mismatches = 0;
  int totalChecks = 0;
  // static codes by flag index, pulsed bytes by strobe from the msb down
  localparam logic [4:0] FCODE [16] = '{5'h00, 5'h03, 5'h04, 5'h06,
    5'h07, 5'h09, 5'h0A, 5'h0E, 5'h0F, 5'h10, 5'h13, 5'h15, 5'h16, 5'h17,
    5'h18, 5'h1D};
  localparam logic [7:0] PCODE [15] = '{8'h01, 8'h81, 8'h02, 8'h05,
    8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h11, 8'h12, 8'h14, 8'h99, 8'h1A, 8'h9A,
    8'h1C};

  // free-running 50 MHz clock
  initial forever #10 sys_clk = ~sys_clk;

  aux_command_decoder dut_u (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .primaryValid(primaryValid),
    .primaryLsb(primaryLsb), .statusUpper(statusUpper), .flags(flags),
    .pulses(pulses), .page(page), .functionsIdle(functionsIdle));

  aux_host_model host_u (.sys_clk(sys_clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData));

  // one comparison, counted
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected effect of one command byte
  task automatic model(input logic [7:0] b, output pulses_t p);
    p = '0;
    if (b[6:5] != 2'b00) return;
    // static flags follow the set bit
    for (int i = 0; i < 16; i++) if (b[4:0] == FCODE[i]) expFlags[i] = b[7];
    for (int i = 0; i < 15; i++) if (b == PCODE[i]) p[14 - i] = 1'b1;
    case (b)
      8'h1E: expPage = PAGE_IRQ_MASK_B;
      8'h1F: expPage = PAGE_BUS_CTRL;
      8'h9E: expPage = PAGE_EOS;
      8'h9F: expPage = PAGE_ACCESSORY;
      8'h9C: expPage = PAGE_NONE;
      // chip reset also drops the address bit
      8'h1C: begin
        expFlags = 16'h0001;
        expPage = PAGE_NONE;
        expUlpa = 1'b0;
      end
      default: ;
    endcase
  endtask

  // issue a command, check the answer cycle and the cycle after
  task automatic cmd(input logic [7:0] b);
    pulses_t p;
    model(b, p);
    host_u.wr(`ADDR_AUX_COMMAND, b);
    #1;
    check(32'(pulses), 32'(p));
    check(flags, expFlags);
    check(page, expPage);
    check(functionsIdle, expFlags[0]);
    @(posedge sys_clk);
    #1 check(32'(pulses), 32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog sized well past the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h7A2148BB));
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1 check(flags, 16'h0001);
    check(page, PAGE_NONE);
    $display("test reset values done");
    // every byte once, reserved ones included
    for (int i = 0; i < 256; i++) begin
      cmd(8'(i));
    end
    $display("test all codes done");
    repeat (150) cmd(8'($urandom));
    $display("test random codes done");
    // a write to another address must not reach the command logic
    host_u.wr(3'h3, 8'h80);
    #1 check(flags, expFlags);
    host_u.rd(3'h7, rd);
    check(rd, 8'h00);
    cmd(8'h83);
    @(posedge sys_clk) reset <= 1'b1;
    @(posedge sys_clk) reset <= 1'b0;
    #1 check(flags, 16'h0001);
    check(page, PAGE_NONE);
    expFlags = 16'h0001;
    expPage = PAGE_NONE;
    $display("test mid-run reset done");
    // primary addresses arrive, status read back
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      primaryValid <= 1'b1;
      primaryLsb <= k[0];
      statusUpper <= 7'($urandom);
      @(posedge sys_clk);
      primaryValid <= 1'b0;
      expUlpa = k[0];
      host_u.rd(`ADDR_ADDRESS_STATUS, rd);
      check(rd, {statusUpper, expUlpa});
      @(posedge sys_clk);
      #1 check(regRdData, 8'h00);
    end
    cmd(8'h1C);
    host_u.rd(`ADDR_ADDRESS_STATUS, rd);
    check(rd, {statusUpper, 1'b0});
    $display("test address status done");
    give_verdict();
  end
endmodule
